// >>> hw/kip_key_input.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module kip_key_input #(
   parameter int         REJECT_CYCLES = kip_pkg::REJECT_CYCLES,
   parameter logic [2:0] REJECT_FITTED = 3'h0
) (
   input  wire logic                    clock,
   input  wire logic                    rstn,
   input  wire logic [11:0]             awaddr,
   input  wire logic                    awvalid,
   output wire logic                    awready,
   input  wire logic [31:0]             wdata,
   input  wire logic [3:0]              wstrb,
   input  wire logic                    wvalid,
   output wire logic                    wready,
   output wire logic [1:0]              bresp,
   output wire logic                    bvalid,
   input  wire logic                    bready,
   input  wire logic [11:0]             araddr,
   input  wire logic                    arvalid,
   output wire logic                    arready,
   output wire logic [31:0]             rdata,
   output wire logic [1:0]              rresp,
   output wire logic                    rvalid,
   input  wire logic                    rready,
   input  wire kip_pkg::kip_pins_t      pins,
   output wire logic [1:0]              eventCountInputs,
   output wire logic                    serialClockTrigger
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [8:0]  pinsS1_reg;            // first synchroniser stage
   logic [8:0]  pinsS2_reg;            // second stage
   logic [8:0]  pinsS3_reg;            // third stage, compared against second
   logic [8:0]  accSeries_reg [3];     // accepted level per terminal series
   logic [15:0] rejCount_reg [3];      // rejector stability counters
   logic [8:0]  accepted;              // accepted level of all nine inputs
   logic [3:0]  groupAEdgeSelect_reg;  // 1 falling, 0 rising
   logic [3:0]  groupAIrqEnable_reg;   // 1 enable, 0 mask
   logic        singleEdgeSelect_reg;  // comparison bit of the single input
   logic        singleIrqEnable_reg;   // enable of the single input
   logic [3:0]  groupCIrqEnable_reg;   // group C enables
   logic        groupAFlag_reg;        // group A factor flag
   logic        singleFlag_reg;        // single input factor flag
   logic        groupCFlag_reg;        // group C factor flag
   logic        mismatchAPrev_reg;     // group A mismatch one cycle ago
   logic        mismatchSPrev_reg;     // single mismatch one cycle ago
   logic        condCPrev_reg;         // group C any-high one cycle ago
   logic        mismatchA;             // enabled group A bits off compare
   logic        mismatchS;             // single bit off compare
   logic        condC;                 // an enabled group C bit is high
   logic        groupAEvent;           // group A interrupt condition
   logic        singleEvent;           // single interrupt condition
   logic        groupCEvent;           // group C interrupt condition
   logic        serialTrigger_reg;     // one-cycle trigger pulse
   logic [1:0]  eventCount_reg;        // event counter inputs
   logic        bvalid_reg;            // write response pending
   logic [1:0]  bresp_reg;             // write response code
   logic        rvalid_reg;            // read data pending
   logic [1:0]  rresp_reg;             // read response code
   logic [31:0] rdata_reg;             // read data
   logic        wrTake;                // write address and data taken
   logic        rdTake;                // read address taken
   logic [9:0]  wrIdx;                 // register index of the write
   logic [9:0]  rdIdx;                 // register index of the read
   logic        wrLow;                 // low byte lane written
   logic        rdHit;                 // read address is mapped
   logic [3:0]  rdField;               // low nibble of the read data
   logic        clrInputFlags;         // read of the input flag register
   logic        clrGroupCFlag;         // read of the group C flag register

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers

   // three stage sync
   // the first stage is read only by the second, never by detection
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         pinsS1_reg <= 9'h000;
         pinsS2_reg <= 9'h000;
         pinsS3_reg <= 9'h000;
      end
      else
      begin
         pinsS1_reg <= pins;
         pinsS2_reg <= pinsS1_reg;
         pinsS3_reg <= pinsS2_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // noise rejector, one per terminal series

   // per-series rejector option
   // without a rejector a level counts once stages two and three agree;
   // with one it must also hold for the rejector time, which filters
   // key bounce at the cost of at least one millisecond of latency
   for (genvar s = 0; s < 3; s++)
   begin : g_series
      logic agree;    // stages two and three equal in this series
      logic differ;   // synchronised level differs from accepted one
      assign agree  = ((pinsS2_reg ^ pinsS3_reg) & kip_pkg::SERIES_MASK[s]) == 9'h000;
      assign differ = ((pinsS3_reg ^ accSeries_reg[s]) & kip_pkg::SERIES_MASK[s]) != 9'h000;

      always_ff @(posedge clock or negedge rstn)
      begin
         if (!rstn)
         begin
            accSeries_reg[s] <= 9'h000;
            rejCount_reg[s]  <= 16'h0000;
         end
         else if (!REJECT_FITTED[s])
         begin
            // no rejector: take the agreed level at once
            if (agree)
            begin
               accSeries_reg[s] <= pinsS3_reg & kip_pkg::SERIES_MASK[s];
            end
            rejCount_reg[s] <= 16'h0000;
         end
         else if (!agree || !differ)
         begin
            // a glitch or no change restarts the stability count
            rejCount_reg[s] <= 16'h0000;
         end
         else if (rejCount_reg[s] == 16'(REJECT_CYCLES - 1))
         begin
            accSeries_reg[s] <= pinsS3_reg & kip_pkg::SERIES_MASK[s];
            rejCount_reg[s]  <= 16'h0000;
         end
         else
         begin
            rejCount_reg[s] <= rejCount_reg[s] + 16'h0001;
         end
      end
   end

   // the series masks do not overlap, so an or merges them
   assign accepted = accSeries_reg[0] | accSeries_reg[1] | accSeries_reg[2];

   ////////////////////////////////////////////////////////////////////////////
   // interrupt condition detection

   // comparison picks the edge
   // a bit matches while it equals its comparison bit, so a 1 there
   // waits for the high level to fall and a 0 for the low level to rise
   assign mismatchA = |((accepted[3:0] ^ groupAEdgeSelect_reg) & groupAIrqEnable_reg);
   assign mismatchS = (accepted[4] ^ singleEdgeSelect_reg) & singleIrqEnable_reg;
   // no edge choice for group C
   assign condC     = |(accepted[8:5] & groupCIrqEnable_reg);

   assign groupAEvent = mismatchA && !mismatchAPrev_reg;
   assign singleEvent = mismatchS && !mismatchSPrev_reg;
   assign groupCEvent = condC && !condCPrev_reg;

   // condition history; mask or compare rewrites count as changes too
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         mismatchAPrev_reg <= 1'b0;
         mismatchSPrev_reg <= 1'b0;
         condCPrev_reg     <= 1'b0;
      end
      else
      begin
         mismatchAPrev_reg <= mismatchA;
         mismatchSPrev_reg <= mismatchS;
         condCPrev_reg     <= condC;
      end
   end

   no_repeat_a : assert property ((mismatchAPrev_reg && mismatchA) |-> !groupAEvent)
      else $error("group A event while already mismatched");
   masked_groupa_a : assert property ((groupAIrqEnable_reg == 4'h0) |-> !groupAEvent)
      else $error("group A event with every bit masked");
   groupc_rise_a : assert property (groupCEvent |-> $past(accepted[8:5] & groupCIrqEnable_reg) == 4'h0)
      else $error("group C event without all enabled bits low before");

   ////////////////////////////////////////////////////////////////////////////
   // factor flags

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         groupAFlag_reg <= kip_pkg::FLAG_RESET;
         singleFlag_reg <= kip_pkg::FLAG_RESET;
      end
      else
      begin
         if (groupAEvent)
         begin
            groupAFlag_reg <= 1'b1;
         end
         else if (clrInputFlags)
         begin
            groupAFlag_reg <= 1'b0;
         end
         if (singleEvent)
         begin
            singleFlag_reg <= 1'b1;
         end
         else if (clrInputFlags)
         begin
            singleFlag_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         groupCFlag_reg <= kip_pkg::FLAG_RESET;
      end
      else if (groupCEvent)
      begin
         groupCFlag_reg <= 1'b1;
      end
      else if (clrGroupCFlag)
      begin
         groupCFlag_reg <= 1'b0;
      end
   end

   groupa_flag_a : assert property (groupAEvent |=> groupAFlag_reg)
      else $error("group A flag not set after its event");
   single_flag_a : assert property (singleEvent |=> singleFlag_reg)
      else $error("single flag not set after its event");
   groupc_flag_a : assert property (groupCEvent |=> groupCFlag_reg)
      else $error("group C flag not set after its event");
   read_clear_a : assert property ((clrInputFlags && !groupAEvent) |=> !groupAFlag_reg)
      else $error("group A flag survived its read");

   ////////////////////////////////////////////////////////////////////////////
   // register writes

   // both channels are taken together; a lone channel simply waits
   assign wrTake  = awvalid && wvalid && !bvalid_reg;
   assign awready = wrTake;
   assign wready  = wrTake;
   assign wrIdx   = awaddr[11:2];
   assign wrLow   = wstrb[0];

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         groupAEdgeSelect_reg <= kip_pkg::EDGE_RESET;
         groupAIrqEnable_reg  <= kip_pkg::EN_RESET;
         singleEdgeSelect_reg <= 1'b0;
         singleIrqEnable_reg  <= 1'b0;
         groupCIrqEnable_reg  <= kip_pkg::EN_RESET;
      end
      else if (wrTake && wrLow)
      begin
         unique case (wrIdx)
            kip_pkg::IDX_GROUP_A_EDGE: groupAEdgeSelect_reg <= wdata[3:0];
            kip_pkg::IDX_GROUP_A_EN:   groupAIrqEnable_reg  <= wdata[3:0];
            kip_pkg::IDX_SINGLE_CTRL:
            begin
               singleEdgeSelect_reg <= wdata[kip_pkg::SINGLE_EDGE_BIT];
               singleIrqEnable_reg  <= wdata[kip_pkg::SINGLE_EN_BIT];
            end
            kip_pkg::IDX_GROUP_C_EN:   groupCIrqEnable_reg  <= wdata[3:0];
            // read-only and unmapped words leave the state alone
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         serialTrigger_reg <= 1'b0;
      end
      else
      begin
         serialTrigger_reg <= wrTake && wrLow && (wrIdx == kip_pkg::IDX_SINGLE_CTRL)
                              && wdata[kip_pkg::SERIAL_TRIG_BIT];
      end
   end

   trig_pulse_a : assert property (serialTrigger_reg |=> !serialTrigger_reg)
      else $error("serial trigger wider than one cycle");

   // write response; unmapped or read-only words answer slave error
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= kip_pkg::RESP_OKAY;
      end
      else if (wrTake)
      begin
         bvalid_reg <= 1'b1;
         unique case (wrIdx)
            kip_pkg::IDX_GROUP_A_EDGE,
            kip_pkg::IDX_GROUP_A_EN,
            kip_pkg::IDX_SINGLE_CTRL,
            kip_pkg::IDX_GROUP_C_EN: bresp_reg <= kip_pkg::RESP_OKAY;
            default:                 bresp_reg <= kip_pkg::RESP_SLVERR;
         endcase
      end
      else if (bready)
      begin
         bvalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register reads

   assign rdTake  = arvalid && !rvalid_reg;
   assign arready = rdTake;
   assign rdIdx   = araddr[11:2];

   // group C flag in D1
   // read mux; flags of other blocks sharing these words read zero here
   always_comb
   begin
      rdHit   = 1'b1;
      rdField = 4'h0;
      unique case (rdIdx)
         kip_pkg::IDX_GROUP_A_PIN:  rdField = accepted[3:0];
         kip_pkg::IDX_GROUP_A_EDGE: rdField = groupAEdgeSelect_reg;
         kip_pkg::IDX_GROUP_A_EN:   rdField = groupAIrqEnable_reg;
         kip_pkg::IDX_SINGLE_CTRL:
         begin
            rdField[kip_pkg::SINGLE_PIN_BIT]  = accepted[4];
            rdField[kip_pkg::SINGLE_EDGE_BIT] = singleEdgeSelect_reg;
            rdField[kip_pkg::SINGLE_EN_BIT]   = singleIrqEnable_reg;
         end
         kip_pkg::IDX_INPUT_FLAGS:
         begin
            rdField[kip_pkg::GROUP_A_FLAG_BIT] = groupAFlag_reg;
            rdField[kip_pkg::SINGLE_FLAG_BIT]  = singleFlag_reg;
         end
         kip_pkg::IDX_GROUP_C_FLAGS: rdField[kip_pkg::GROUP_C_FLAG_BIT] = groupCFlag_reg;
         kip_pkg::IDX_GROUP_C_PIN:   rdField = accepted[8:5];
         kip_pkg::IDX_GROUP_C_EN:    rdField = groupCIrqEnable_reg;
         default:                    rdHit   = 1'b0;
      endcase
   end

   assign clrInputFlags = rdTake && (rdIdx == kip_pkg::IDX_INPUT_FLAGS);
   assign clrGroupCFlag = rdTake && (rdIdx == kip_pkg::IDX_GROUP_C_FLAGS);

   // read data is captured when the address is taken
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         rvalid_reg <= 1'b0;
         rresp_reg  <= kip_pkg::RESP_OKAY;
         rdata_reg  <= 32'h0000_0000;
      end
      else if (rdTake)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= {28'h000_0000, rdField};
         rresp_reg  <= rdHit ? kip_pkg::RESP_OKAY : kip_pkg::RESP_SLVERR;
      end
      else if (rready)
      begin
         rvalid_reg <= 1'b0;
      end
   end

   flag_readout_a : assert property (clrInputFlags && groupAFlag_reg |=> rdata_reg[2] && rvalid_reg)
      else $error("set group A flag not returned on read");
   upper_zero_a : assert property (rvalid_reg |-> rdata_reg[31:4] == 28'h000_0000)
      else $error("unused read bits not zero");

   ////////////////////////////////////////////////////////////////////////////
   // event counter feed and outputs

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         eventCount_reg <= 2'h0;
      end
      else
      begin
         eventCount_reg <= accepted[3:2];
      end
   end

   assign eventCountInputs   = eventCount_reg;
   assign serialClockTrigger = serialTrigger_reg;
   assign bvalid             = bvalid_reg;
   assign bresp              = bresp_reg;
   assign rvalid             = rvalid_reg;
   assign rresp              = rresp_reg;
   assign rdata              = rdata_reg;

endmodule

// >>> hw/kip_pkg.sv
// shared constants and types for the key input port
package kip_pkg;

   // bus address width in bits; register index is the byte address over four
   localparam int ADDR_W = 12;

   // register indices, byte address is index times four
   localparam logic [9:0] IDX_GROUP_A_PIN   = 10'h2e3;
   localparam logic [9:0] IDX_GROUP_A_EDGE  = 10'h2e4;
   localparam logic [9:0] IDX_GROUP_A_EN    = 10'h2e5;
   localparam logic [9:0] IDX_SINGLE_CTRL   = 10'h2e7;
   localparam logic [9:0] IDX_INPUT_FLAGS   = 10'h2ea;
   localparam logic [9:0] IDX_GROUP_C_FLAGS = 10'h2f3;
   localparam logic [9:0] IDX_GROUP_C_PIN   = 10'h2f4;
   localparam logic [9:0] IDX_GROUP_C_EN    = 10'h2f5;

   // field positions inside the single bit control register
   localparam int SINGLE_PIN_BIT  = 0;
   localparam int SINGLE_EDGE_BIT = 1;
   localparam int SINGLE_EN_BIT   = 2;
   localparam int SERIAL_TRIG_BIT = 3;

   // field positions of the factor flags
   localparam int GROUP_A_FLAG_BIT = 2;
   localparam int SINGLE_FLAG_BIT  = 3;
   localparam int GROUP_C_FLAG_BIT = 1;

   // reset values
   localparam logic [3:0] EDGE_RESET = 4'h0;
   localparam logic [3:0] EN_RESET   = 4'h0;
   localparam logic       FLAG_RESET = 1'b0;

   // noise rejector delay, longest time so it rounds down
   localparam int CLOCK_KHZ      = 40000;
   localparam int REJECT_TIME_US = 1000;
   localparam int REJECT_CYCLES  = REJECT_TIME_US * CLOCK_KHZ / 1000;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // the nine input pins as one carrier
   typedef struct packed {
      logic [3:0] groupC;
      logic       single;
      logic [3:0] groupA;
   } kip_pins_t;

   // which bits of the nine belong to each terminal series
   localparam logic [8:0] SERIES_MASK [3] = '{9'h00f, 9'h010, 9'h1e0};

endpackage

// >>> sim/kip_switch_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// far side of the port: switches and other chips driving the nine pins
module kip_switch_model (
   input  wire logic               clock,
   input  wire kip_pkg::kip_pins_t want,
   input  wire logic               slow,
   output wire kip_pkg::kip_pins_t pins
);
   kip_pkg::kip_pins_t levelReg = '0;   // level seen on the pins
   logic [1:0]         holdCount = '0;  // cycles a slow contact has waited

   // a slow contact only reaches its new level after four cycles,
   // so the block cannot rely on a pin moving at the moment it is asked to
   always @(posedge clock)
   begin
      if (!slow || holdCount == 2'h3)
      begin
         levelReg <= want;
         holdCount <= '0;
      end
      else if (want != levelReg)
         holdCount <= holdCount + 2'h1;
   end

   assign pins = levelReg;
endmodule

// >>> sim/key_input_port_interrupt_test.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module key_input_port_interrupt_test;
   localparam logic [1:0] OK = kip_pkg::RESP_OKAY;     // normal answer
   localparam logic [1:0] ERR = kip_pkg::RESP_SLVERR;  // refused access
   localparam int         SETTLE = 24;                 // sync, rejector and flag margin

   logic                  clock = 1'b0;                // 40 MHz core clock
   logic                  rstn = 1'b0;                 // initial reset
   logic [11:0]           awaddr = '0, araddr = '0;
   logic [31:0]           wdata = '0;
   logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic                  arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
   wire logic             awready, wready, bvalid, arready, rvalid, serialClockTrigger;
   wire logic [1:0]       bresp, rresp, eventCountInputs;
   wire logic [31:0]      rdata;
   kip_pkg::kip_pins_t    want = '0;                   // level asked of the switches
   wire kip_pkg::kip_pins_t pins;
   int                    num_errors = 0, compares = 0, trigCount = 0;

   initial
      forever #12.5 clock = ~clock;

   // group c has the rejector fitted, shortened to eight cycles
   kip_key_input #(.REJECT_CYCLES(8), .REJECT_FITTED(3'h4)) dut_u (
      .clock(clock), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .pins(pins), .eventCountInputs(eventCountInputs),
      .serialClockTrigger(serialClockTrigger));

   kip_switch_model switch_u (.clock(clock), .want(want), .slow(slow), .pins(pins));

   // count trigger pulses, each must last one cycle
   always @(posedge clock)
      if (serialClockTrigger === 1'b1)
         trigCount++;

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one clock edge with a bound on the whole wait
   task automatic step(inout int n);
      @(posedge clock);
      n++;
      if (n > 200)
      begin
         num_errors++;
         $display("bus answer never came");
         tally_and_finish();
      end
   endtask

   task automatic wr(input logic [9:0] idx, input logic [3:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clock);
      awaddr <= {idx, 2'b00};
      wdata <= {28'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      step(n);
      while (awready !== 1'b1 || wready !== 1'b1) step(n);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      step(n);
      while (bvalid !== 1'b1) step(n);
      bready <= 1'b0;
      check($sformatf("bresp %h", idx), {30'h0, bresp}, {30'h0, er});
   endtask

   task automatic rd(input logic [9:0] idx, input logic [3:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clock);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      step(n);
      while (arready !== 1'b1) step(n);
      arvalid <= 1'b0;
      step(n);
      while (rvalid !== 1'b1) step(n);
      rready <= 1'b0;
      check($sformatf("rdata %h", idx), rdata, {28'h0, d});
      check($sformatf("rresp %h", idx), {30'h0, rresp}, {30'h0, er});
   endtask

   // ask for new pin levels, then give them a set time to land
   task automatic pinsTo(input logic [8:0] p, input logic s, input int w);
      @(posedge clock);
      want <= p;
      slow <= s;
      repeat (w) @(posedge clock);
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      rd(kip_pkg::IDX_GROUP_A_EDGE, 4'h0, OK);
      rd(kip_pkg::IDX_GROUP_A_EN, 4'h0, OK);
      rd(kip_pkg::IDX_SINGLE_CTRL, 4'h0, OK);
      rd(kip_pkg::IDX_INPUT_FLAGS, 4'h0, OK);
      rd(kip_pkg::IDX_GROUP_C_FLAGS, 4'h0, OK);
      rd(kip_pkg::IDX_GROUP_C_EN, 4'h0, OK);
      $display("test reset values done");
      // masks and flags only touched with the processor's interrupts off
      // software discipline
      wr(kip_pkg::IDX_GROUP_A_EN, 4'he, OK);
      rd(kip_pkg::IDX_GROUP_A_EN, 4'he, OK);
      pinsTo(9'h001, 1'b0, SETTLE);
      rd(kip_pkg::IDX_INPUT_FLAGS, 4'h0, OK);
      pinsTo(9'h009, 1'b0, SETTLE);
      rd(kip_pkg::IDX_INPUT_FLAGS, 4'h4, OK);
      rd(kip_pkg::IDX_INPUT_FLAGS, 4'h0, OK);
      pinsTo(9'h00d, 1'b0, SETTLE);
      rd(kip_pkg::IDX_INPUT_FLAGS, 4'h0, OK);
      rd(kip_pkg::IDX_GROUP_A_PIN, 4'hd, OK);
      check("eventCountInputs", {30'h0, eventCountInputs}, 32'h3);
      // compare rewritten with the group masked, then falling edge on bit 2
      wr(kip_pkg::IDX_GROUP_A_EN, 4'h0, OK);
      wr(kip_pkg::IDX_GROUP_A_EDGE, 4'hd, OK);
      rd(kip_pkg::IDX_GROUP_A_EDGE, 4'hd, OK);
      wr(kip_pkg::IDX_GROUP_A_EN, 4'hf, OK);
      rd(kip_pkg::IDX_INPUT_FLAGS, 4'h0, OK);
      pinsTo(9'h009, 1'b0, SETTLE);
      rd(kip_pkg::IDX_INPUT_FLAGS, 4'h4, OK);
      $display("test group a done");
      pinsTo(9'h019, 1'b0, SETTLE);
      wr(kip_pkg::IDX_SINGLE_CTRL, 4'h6, OK);
      rd(kip_pkg::IDX_SINGLE_CTRL, 4'h7, OK);
      pinsTo(9'h009, 1'b0, SETTLE);
      rd(kip_pkg::IDX_INPUT_FLAGS, 4'h8, OK);
      $display("test single bit done");
      wr(kip_pkg::IDX_GROUP_C_EN, 4'h7, OK);
      pinsTo(9'h109, 1'b0, SETTLE);
      rd(kip_pkg::IDX_GROUP_C_FLAGS, 4'h0, OK);
      // slow contact plus rejector: flag is still low shortly after,
      // where an unfiltered series would already have set it
      pinsTo(9'h149, 1'b1, 10);
      rd(kip_pkg::IDX_GROUP_C_FLAGS, 4'h0, OK);
      repeat (SETTLE) @(posedge clock);
      rd(kip_pkg::IDX_GROUP_C_FLAGS, 4'h2, OK);
      rd(kip_pkg::IDX_GROUP_C_PIN, 4'ha, OK);
      pinsTo(9'h1c9, 1'b0, SETTLE);
      rd(kip_pkg::IDX_GROUP_C_FLAGS, 4'h0, OK);
      $display("test group c done");
      wr(kip_pkg::IDX_GROUP_A_PIN, 4'h0, ERR);
      rd(kip_pkg::IDX_GROUP_A_PIN, 4'h9, OK);
      rd(10'h000, 4'h0, ERR);
      wr(10'h000, 4'hf, ERR);
      wr(kip_pkg::IDX_SINGLE_CTRL, 4'he, OK);
      rd(kip_pkg::IDX_SINGLE_CTRL, 4'h6, OK);
      check("trigger pulses", trigCount, 32'h1);
      // single input switched to rising edge, then the pin rises
      wr(kip_pkg::IDX_SINGLE_CTRL, 4'h4, OK);
      pinsTo(9'h1d9, 1'b0, SETTLE);
      rd(kip_pkg::IDX_INPUT_FLAGS, 4'h8, OK);
      $display("test bus and trigger done");
      tally_and_finish();
   end
endmodule
